// ===== design/sipr_top.sv
// system integration unit: pending status, break protection, low power, reset cause
//
// Behaviour
// - status a shows sources one to six
// - status b shows sources seven to fourteen
// - status c shows sources fifteen to twenty-two
// - status d shows sources 23, 24 only
// - flag reads one while request present
// - all resets equal, no arbitration
// - break forces fetch from software interrupt vector
// - break protects flags unless clear enable
// - flag cleared in break stays cleared
// - two-step clears blocked during break only
// - wait or stop clears interrupt mask
// - wait stops core clock, interrupt wakes
// - break exit from wait sets flag
// - watchdog runs in wait unless disabled
// - stop halts clocks, interrupt exits
// - stop recovery 4096 or 32 cycles
// - counter held in stop, times recovery
// - reading cause register clears it
// - drive reset pin, sample 32 later
// - separate flags for each reset source
`timescale 1ns/1ps
module sipr_top
    import sipr_pkg::*;
#(
    parameter int STOP_LONG_CYC = SIPR_STOP_LONG_CYC
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources and core
    input wire logic [SIPR_NSRC:1] irq_src,
    input wire sipr_core_t core_req,
    input wire logic [4:0] irq_prio_in,
    // reset sources, por is the async presetn
    input wire logic [5:0] reset_src,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // clocks and core control
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic clear_imask,
    output logic force_swi_vector,
    output logic stack_start,
    output logic [4:0] irq_win,
    output logic break_active,
    output logic flag_clear_ok,
    output logic watchdog_run
);
    sipr_state_t state_q;
    logic [7:0] bfc_q, opt_q, rcs_q;
    logic wait_exited_by_break_q;
    logic [12:0] cnt_q;
    logic [5:0] pin_cnt_q;
    logic [2:0] pin_sync_q;
    logic pin_drive_q;
    logic [SIPR_NSRC:1] pend_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [4:0] win_q;
    logic swi_q, imask_q, stack_q;
    logic any_irq;
    logic apb_wr, apb_rd, apb_setup, apb_acc;
    logic pin_low_q;
    logic [15:0] idx;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        return a == r;
    endfunction

    // cause inputs sit at register bits 6..1, bit 0 unused
    function automatic logic [7:0] cause_bits(input logic [5:0] src);
        return {1'b0, src, 1'b0};
    endfunction

    assign idx = paddr[17:2];
    assign apb_setup = psel & ~penable;
    // writes and read-clear land only at the completing access edge
    assign apb_acc = psel & penable & pready_q;
    assign apb_wr = apb_acc & pwrite;
    assign apb_rd = apb_acc & ~pwrite;
    assign any_irq = |pend_q;

    // sample live requests
    // one snapshot per clock, so all status reads agree with the arbiter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= irq_src;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_q <= 5'h00;
        end else begin
            win_q <= 5'h00;
            for (int i = SIPR_NSRC; i >= 1; i--) begin
                if (pend_q[i]) begin
                    win_q <= 5'(i);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SIPR_RUN;
        end else begin
            case (state_q)
                SIPR_RUN: begin
                    if (core_req.break_req) begin
                        state_q <= SIPR_BREAK;
                    end else if (core_req.stop_exec) begin
                        state_q <= SIPR_STOP;
                    end else if (core_req.wait_exec) begin
                        state_q <= SIPR_WAIT;
                    end
                end
                SIPR_WAIT: begin
                    if (core_req.break_req) begin
                        state_q <= SIPR_BREAK;
                    end else if (any_irq) begin
                        state_q <= SIPR_STACK;
                    end
                end
                SIPR_STOP: begin
                    if (any_irq) begin
                        state_q <= SIPR_RECOVER;
                    end
                end
                SIPR_RECOVER: begin
                    if (cnt_q == 13'h0001) begin
                        state_q <= SIPR_STACK;
                    end
                end
                SIPR_STACK: begin
                    state_q <= SIPR_RUN;
                end
                SIPR_BREAK: begin
                    if (core_req.break_done) begin
                        state_q <= SIPR_RUN;
                    end
                end
                default: begin
                    state_q <= SIPR_RUN;
                end
            endcase
        end
    end

    // recovery count chosen by option bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 13'h0000;
        end else if (state_q == SIPR_STOP) begin
            if (any_irq) begin
                cnt_q <= opt_q[SIPR_OPT_SHORT_STOP_RECOVERY] ? 13'(SIPR_STOP_SHORT_CYC) : 13'(STOP_LONG_CYC);
            end else begin
                cnt_q <= 13'h0000;
            end
        end else if (state_q == SIPR_RECOVER && cnt_q != 13'h0000) begin
            cnt_q <= cnt_q - 13'h0001;
        end else begin
            cnt_q <= 13'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= 1'b0;
            swi_q <= 1'b0;
            stack_q <= 1'b0;
        end else begin
            imask_q <= (state_q == SIPR_RUN) & (core_req.wait_exec | core_req.stop_exec);
            swi_q <= core_req.break_req & (state_q == SIPR_RUN || state_q == SIPR_WAIT);
            stack_q <= (state_q == SIPR_STACK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_exited_by_break_q <= 1'b0;
        end else if (state_q == SIPR_WAIT && core_req.break_req) begin
            wait_exited_by_break_q <= 1'b1;
        end else if (apb_wr && hit(idx, SIPR_IDX_BWS) && !pwdata[SIPR_BWS_WAIT_EXITED_BY_BREAK]) begin
            wait_exited_by_break_q <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bfc_q <= SIPR_BFC_RST;
            opt_q <= SIPR_OPT_RST;
        end else if (apb_wr) begin
            if (hit(idx, SIPR_IDX_BFC)) begin
                bfc_q <= pwdata[7:0] & 8'h80;
            end else if (hit(idx, SIPR_IDX_OPT)) begin
                opt_q <= pwdata[7:0] & 8'h07;
            end
        end
    end

    // hold pin low, then sample later
    // internal causes only: an external pin reset already holds the pin low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_drive_q <= 1'b1;
            pin_cnt_q <= 6'h00;
        end else if (|reset_src[4:0]) begin
            pin_drive_q <= 1'b1;
            pin_cnt_q <= 6'h00;
        end else if (pin_drive_q) begin
            pin_drive_q <= 1'b0;
            pin_cnt_q <= 6'(SIPR_PIN_SAMPLE_CYC);
        end else if (pin_cnt_q != 6'h00) begin
            pin_cnt_q <= pin_cnt_q - 6'h01;
        end
    end

    // pin synchroniser, stage one read only by stage two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_q <= 3'b111;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], rst_pin_in};
        end
    end

    // read clears, power-on sets por only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcs_q <= SIPR_RCS_POR_VAL;
        end else begin
            if (apb_rd && hit(idx, SIPR_IDX_RCS)) begin
                rcs_q <= cause_bits(reset_src);
            end else begin
                rcs_q <= rcs_q | cause_bits(reset_src);
            end
            if (pin_cnt_q == 6'h01 && !pin_sync_q[2] && !pin_sync_q[1]) begin
                rcs_q[6] <= 1'b1;
            end
        end
    end

    // apb slave, zero wait state, read data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (apb_setup) begin
                if (hit(idx, SIPR_IDX_BWS)) begin
                    prdata_q[SIPR_BWS_WAIT_EXITED_BY_BREAK] <= wait_exited_by_break_q;
                end else if (hit(idx, SIPR_IDX_RCS)) begin
                    prdata_q[7:0] <= rcs_q;
                end else if (hit(idx, SIPR_IDX_BFC)) begin
                    prdata_q[7:0] <= bfc_q;
                end else if (hit(idx, SIPR_IDX_IRQA)) begin
                    prdata_q[7:0] <= {pend_q[6:1], 2'b00};
                end else if (hit(idx, SIPR_IDX_IRQB)) begin
                    prdata_q[7:0] <= pend_q[14:7];
                end else if (hit(idx, SIPR_IDX_IRQC)) begin
                    prdata_q[7:0] <= pend_q[22:15];
                end else if (hit(idx, SIPR_IDX_IRQD)) begin
                    prdata_q[7:0] <= {6'b000000, pend_q[24:23]};
                end else if (hit(idx, SIPR_IDX_OPT)) begin
                    prdata_q[7:0] <= opt_q;
                end else if (hit(idx, SIPR_IDX_CMD)) begin
                    prdata_q[2:0] <= state_q;
                end else begin
                    pslverr_q <= 1'b1;
                end
                if (pwrite && idx >= SIPR_IDX_IRQA && idx <= SIPR_IDX_IRQD) begin
                    pslverr_q <= 1'b0;
                end
            end
        end
    end

    // core-facing outputs registered
    logic core_clk_q, periph_clk_q, brk_q, clr_ok_q, wd_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clk_q <= 1'b1;
            periph_clk_q <= 1'b1;
            brk_q <= 1'b0;
            clr_ok_q <= 1'b1;
            wd_q <= 1'b0;
        end else begin
            core_clk_q <= (state_q == SIPR_RUN) || (state_q == SIPR_STACK)
                || (state_q == SIPR_BREAK);
            periph_clk_q <= (state_q != SIPR_STOP) && (state_q != SIPR_RECOVER);
            brk_q <= (state_q == SIPR_BREAK);
            // second step gated only while in break
            clr_ok_q <= (state_q != SIPR_BREAK) || bfc_q[SIPR_BFC_BREAK_CLEAR_ENABLE];
            wd_q <= !opt_q[SIPR_OPT_WDDIS] && (state_q != SIPR_STOP)
                && (state_q != SIPR_RECOVER);
        end
    end

    // pin level while driven; the enable alone decides when it drives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_q <= 1'b0;
        end else begin
            pin_low_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rst_pin_out = pin_low_q;
    assign rst_pin_oe = pin_drive_q;
    assign core_clk_en = core_clk_q;
    assign periph_clk_en = periph_clk_q;
    assign clear_imask = imask_q;
    assign force_swi_vector = swi_q;
    assign stack_start = stack_q;
    assign irq_win = win_q;
    assign break_active = brk_q;
    assign flag_clear_ok = clr_ok_q;
    assign watchdog_run = wd_q;
endmodule // sipr_top

// ===== include/sipr_pkg.sv
// shared constants and types for the system integration power and reset block
package sipr_pkg;
    // register word indices; the byte address on the bus is the index times four
    localparam logic [15:0] SIPR_IDX_BWS = 16'hFE00;
    localparam logic [15:0] SIPR_IDX_RCS = 16'hFE01;
    localparam logic [15:0] SIPR_IDX_BFC = 16'hFE03;
    localparam logic [15:0] SIPR_IDX_IRQA = 16'hFE04;
    localparam logic [15:0] SIPR_IDX_IRQB = 16'hFE05;
    localparam logic [15:0] SIPR_IDX_IRQC = 16'hFE06;
    localparam logic [15:0] SIPR_IDX_IRQD = 16'hFE07;
    localparam logic [15:0] SIPR_IDX_OPT = 16'hFE08;
    localparam logic [15:0] SIPR_IDX_CMD = 16'hFE09;
    // field positions
    localparam int SIPR_BWS_WAIT_EXITED_BY_BREAK = 1;
    localparam int SIPR_BFC_BREAK_CLEAR_ENABLE = 7;
    localparam int SIPR_OPT_SHORT_STOP_RECOVERY = 0;
    localparam int SIPR_OPT_WDDIS = 1;
    localparam int SIPR_OPT_OSCSTOP = 2;
    localparam int SIPR_CMD_WAIT = 0;
    localparam int SIPR_CMD_STOP = 1;
    // reset values
    localparam logic [7:0] SIPR_RCS_POR_VAL = 8'h80;
    localparam logic [7:0] SIPR_OPT_RST = 8'h00;
    localparam logic [7:0] SIPR_BFC_RST = 8'h00;
    // timing counts in oscillator cycles
    localparam int SIPR_STOP_LONG_CYC = 4096;
    localparam int SIPR_STOP_SHORT_CYC = 32;
    localparam int SIPR_PIN_SAMPLE_CYC = 32;
    localparam int SIPR_NSRC = 24;
    typedef enum logic [2:0] {
        SIPR_RUN, SIPR_WAIT, SIPR_STOP, SIPR_RECOVER, SIPR_STACK, SIPR_BREAK
    } sipr_state_t;
    // reset cause bits, in register order from bit 7 down to bit 1
    typedef struct packed {
        logic por;
        logic pin;
        logic watchdog;
        logic bad_instr;
        logic bad_fetch;
        logic monitor;
        logic low_volt;
    } sipr_cause_t;
    // core requests into the block
    typedef struct packed {
        logic wait_exec;
        logic stop_exec;
        logic break_req;
        logic break_done;
    } sipr_core_t;
endpackage

// ===== tb/sipr_top_sva.sv
// assertion checker for the system integration power and reset block
`timescale 1ns/1ps
module sipr_top_sva
    import sipr_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire sipr_core_t core_req,
    input wire logic rst_pin_out,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic clear_imask,
    input wire logic force_swi_vector,
    input wire logic flag_clear_ok,
    input wire logic break_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(logic [15:0] idx);
        pready && !pwrite && paddr[17:2] == idx;
    endsequence
    a_ready_next: assert property (s_setup |=> pready && psel && penable)
        else $error("pready late");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_stat_a_low: assert property (s_rd(SIPR_IDX_IRQA) |-> prdata[1:0] == 2'h0)
        else $error("status a low bits set");
    a_stat_d_top: assert property (s_rd(SIPR_IDX_IRQD) |-> prdata[31:2] == 30'h0)
        else $error("status d upper bits set");
    a_break_swi: assert property ($rose(core_req.break_req) |-> ##[1:3] force_swi_vector)
        else $error("no vector force on break");
    a_idle_clear_ok: assert property (!break_active |-> ##[0:2] flag_clear_ok)
        else $error("flags protected outside break");
    a_wait_imask: assert property ($rose(core_req.wait_exec) |-> ##[1:3] clear_imask)
        else $error("mask not cleared on wait");
    a_stop_both: assert property (!periph_clk_en |-> !core_clk_en)
        else $error("core clock runs in stop");
    a_pin_low_level: assert property (rst_pin_out == 1'b0)
        else $error("reset pin driven high");
endmodule // sipr_top_sva

bind sipr_top sipr_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .core_req, .rst_pin_out, .core_clk_en, .periph_clk_en,
    .clear_imask, .force_swi_vector, .flag_clear_ok, .break_active);

// ===== tb/sipr_core_model.sv
// core and peripheral stand-in: requests, reset causes and the reset pin
`timescale 1ns/1ps
module sipr_core_model
    import sipr_pkg::*;
(
    // clock
    input wire logic pclk,
    // towards the block
    output logic [SIPR_NSRC:1] irq_src,
    output sipr_core_t core_req,
    output logic [5:0] reset_src,
    output logic rst_pin_in,
    // pin drive from the block
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe
);
    logic hold_low;
    // pin has a pull-up, so a released pin reads high unless held low outside
    assign rst_pin_in = ((rst_pin_oe && !rst_pin_out) || hold_low) ? 1'b0 : 1'b1;
    initial begin
        hold_low = 1'b0;
        irq_src = '0;
        core_req = '0;
        reset_src = '0;
    end
    task set_irq(input logic [SIPR_NSRC:1] v);
        @(posedge pclk);
        irq_src <= v;
    endtask
    task set_pin_hold(input logic v);
        @(posedge pclk);
        hold_low <= v;
    endtask
    task set_reset(input logic [5:0] v);
        @(posedge pclk);
        reset_src <= v;
    endtask
    task pulse_core(input sipr_core_t v);
        @(posedge pclk);
        core_req <= v;
        @(posedge pclk);
        core_req <= '0;
    endtask
endmodule // sipr_core_model

// ===== tb/sipr_top_tb.sv
// self-checking bench for the system integration power and reset block
`timescale 1ns/1ps
module sipr_top_tb;
    import sipr_pkg::*;
    // short long-recovery count keeps the run brief
    localparam int LONG_CYC = 40;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [SIPR_NSRC:1] irq_src;
    sipr_core_t core_req;
    logic [5:0] reset_src;
    logic [4:0] irq_win, irq_prio_in;
    logic rst_pin_in, rst_pin_out, rst_pin_oe, core_clk_en, periph_clk_en, clear_imask;
    logic force_swi_vector, stack_start, break_active, flag_clear_ok, watchdog_run;
    int n_errors = 0;
    int check_count = 0;
    sipr_top #(.STOP_LONG_CYC(LONG_CYC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_src(irq_src), .core_req(core_req),
        .irq_prio_in(irq_prio_in), .reset_src(reset_src), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .core_clk_en(core_clk_en),
        .periph_clk_en(periph_clk_en), .clear_imask(clear_imask),
        .force_swi_vector(force_swi_vector), .stack_start(stack_start), .irq_win(irq_win),
        .break_active(break_active), .flag_clear_ok(flag_clear_ok),
        .watchdog_run(watchdog_run));
    sipr_core_model cpu (.pclk(pclk), .irq_src(irq_src), .core_req(core_req),
        .reset_src(reset_src), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task close_out;
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic wait_on(input int which, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < 6000) begin
            @(posedge pclk);
            n++;
            case (which)
                0: hit = stack_start === 1'b1;
                1: hit = force_swi_vector === 1'b1;
                2: hit = clear_imask === 1'b1;
                default: hit = rst_pin_oe === 1'b0;
            endcase
        end
        if (!hit) begin
            n_errors++;
            close_out();
        end
    endtask
    task t_regs;
        apb(1'b0, SIPR_IDX_RCS, 8'h00);
        chk(rd, {24'h0, SIPR_RCS_POR_VAL});
        apb(1'b1, SIPR_IDX_RCS, 8'hFF);
        apb(1'b0, SIPR_IDX_RCS, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, SIPR_IDX_BFC, 8'h00);
        chk(rd, {24'h0, SIPR_BFC_RST});
        apb(1'b0, 16'hFE02, 8'h00);
        chk(32'(err), 32'h1);
    endtask
    task t_status;
        logic [24:1] p;
        logic [7:0] e [4];
        for (int k = 0; k < 2; k++) begin
            p = k ? 24'h5A3C96 : 24'hA5C369;
            e[0] = {p[6:1], 2'b00};
            e[1] = p[14:7];
            e[2] = p[22:15];
            e[3] = {6'h00, p[24:23]};
            cpu.set_irq(p);
            for (int r = 0; r < 4; r++) begin
                apb(1'b1, SIPR_IDX_IRQA + 16'(r), 8'hFF);
                chk(32'(err), 32'h0);
                apb(1'b0, SIPR_IDX_IRQA + 16'(r), 8'h00);
                chk(rd, {24'h0, e[r]});
            end
            chk(32'(irq_win), k ? 32'h2 : 32'h1);
        end
        cpu.set_irq('0);
    endtask
    task t_resets;
        int n;
        for (int i = 0; i < 6; i++) begin
            cpu.set_reset(6'(1 << i));
            repeat (3) @(posedge pclk);
            chk(32'(rst_pin_oe), (i == 5) ? 32'h0 : 32'h1);
            cpu.set_reset(6'h00);
            wait_on(3, n);
            repeat (SIPR_PIN_SAMPLE_CYC + 8) @(posedge pclk);
            apb(1'b0, SIPR_IDX_RCS, 8'h00);
            chk(rd, 32'(1 << (i + 1)));
        end
        // pin still held low outside at the sample point adds the pin flag
        cpu.set_pin_hold(1'b1);
        cpu.set_reset(6'h01);
        repeat (3) @(posedge pclk);
        cpu.set_reset(6'h00);
        wait_on(3, n);
        repeat (SIPR_PIN_SAMPLE_CYC + 8) @(posedge pclk);
        cpu.set_pin_hold(1'b0);
        apb(1'b0, SIPR_IDX_RCS, 8'h00);
        chk(rd, 32'h0000_0042);
    endtask
    task t_break;
        int n;
        apb(1'b1, SIPR_IDX_BFC, 8'h00);
        fork cpu.pulse_core(4'h2); wait_on(1, n); join
        repeat (2) @(posedge pclk);
        chk(32'(break_active), 32'h1);
        chk(32'(flag_clear_ok), 32'h0);
        apb(1'b1, SIPR_IDX_BFC, 8'h80);
        repeat (2) @(posedge pclk);
        chk(32'(flag_clear_ok), 32'h1);
        apb(1'b1, SIPR_IDX_BFC, 8'h00);
        repeat (2) @(posedge pclk);
        chk(32'(flag_clear_ok), 32'h0);
        cpu.pulse_core(4'h1);
        repeat (3) @(posedge pclk);
        chk(32'(flag_clear_ok), 32'h1);
    endtask
    task t_wait;
        int n;
        apb(1'b1, SIPR_IDX_OPT, SIPR_OPT_RST);
        fork cpu.pulse_core(4'h8); wait_on(2, n); join
        repeat (3) @(posedge pclk);
        chk({30'h0, core_clk_en, periph_clk_en}, 32'h1);
        chk(32'(watchdog_run), 32'h1);
        cpu.set_irq(24'h000001);
        wait_on(0, n);
        chk(32'(n <= 4), 32'h1);
        cpu.set_irq('0);
        fork cpu.pulse_core(4'h8); wait_on(2, n); join
        repeat (3) @(posedge pclk);
        fork cpu.pulse_core(4'h2); wait_on(1, n); join
        apb(1'b0, SIPR_IDX_BWS, 8'h00);
        chk(32'(rd[SIPR_BWS_WAIT_EXITED_BY_BREAK]), 32'h1);
        apb(1'b1, SIPR_IDX_BWS, 8'h00);
        apb(1'b0, SIPR_IDX_BWS, 8'h00);
        chk(32'(rd[SIPR_BWS_WAIT_EXITED_BY_BREAK]), 32'h0);
        cpu.pulse_core(4'h1);
    endtask
    task t_stop;
        int n, ncyc;
        for (int k = 0; k < 2; k++) begin
            ncyc = k ? LONG_CYC : SIPR_STOP_SHORT_CYC;
            // short recovery chosen by option bit 0 alone; the oscillator-stop bit set with it is unused
            apb(1'b1, SIPR_IDX_OPT, k ? 8'h00 : 8'h05);
            fork cpu.pulse_core(4'h4); wait_on(2, n); join
            repeat (3) @(posedge pclk);
            chk({30'h0, core_clk_en, periph_clk_en}, 32'h0);
            cpu.set_irq(24'h800000);
            wait_on(0, n);
            chk(32'(n >= ncyc && n <= ncyc + 8), 32'h1);
            cpu.set_irq('0);
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        irq_prio_in = 5'h1F;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_status();
        t_resets();
        t_break();
        t_wait();
        t_stop();
        close_out();
    end
endmodule // sipr_top_tb
